// ==== verilog/cmr_defs.svh ====
`ifndef CMR_DEFS_SVH
`define CMR_DEFS_SVH

// register byte offsets on the Avalon-MM slave
`define CMR_OFF_CTRL      6'h00
`define CMR_OFF_MODAL0    6'h04
`define CMR_OFF_RATIO0    6'h14
`define CMR_OFF_STATUS    6'h24
`define CMR_OFF_EFFRATIO  6'h28
`define CMR_SET_SPAN      6'h10

// control register field positions
`define CMR_CTRL_LOCK_POL 0
`define CMR_CTRL_OWU      1
`define CMR_CTRL_FMT      2
`define CMR_CTRL_CFG_LSB  3
`define CMR_CTRL_CFG_MSB  5
`define CMR_CTRL_KIT      6

// modal set field positions
`define CMR_MODAL_RMOD_LSB 0
`define CMR_MODAL_RMOD_MSB 1
`define CMR_MODAL_AUX_LSB  2
`define CMR_MODAL_AUX_MSB  3

// reset values
`define CMR_CTRL_RST      7'h00
`define CMR_MODAL_RST     4'h4
`define CMR_RATIO_RST     32'h0000_1000

// timing
`define CMR_SYS_CLK_NS    4
`define CMR_RELOCK_NS     400
`define CMR_RELOCK_CYC    ((`CMR_RELOCK_NS + `CMR_SYS_CLK_NS - 1) / `CMR_SYS_CLK_NS)
`define CMR_REF_TIMEOUT_NS 20000000
`define CMR_REF_TIMEOUT_CYC (`CMR_REF_TIMEOUT_NS / `CMR_SYS_CLK_NS)
`define CMR_INIT_TOGGLES  2'h3

// reference drift window, in tenths of the starting period
`define CMR_DRIFT_SCALE   4'hA
`define CMR_DRIFT_HI      4'hD
`define CMR_DRIFT_LO      4'h7

`endif

// ==== verilog/cmr_pkg.sv ====
package cmr_pkg;

    typedef enum logic [1:0] {
        CMR_AUX_RESV  = 2'h0,
        CMR_AUX_REF   = 2'h1,
        CMR_AUX_SYNTH = 2'h2,
        CMR_AUX_LOCK  = 2'h3
    } cmr_aux_src_t;

    typedef enum logic [2:0] {
        CMR_CFG_DIS_SYNTH = 3'h0,
        CMR_CFG_DIS_AUX   = 3'h1,
        CMR_CFG_DIS_BOTH  = 3'h2,
        CMR_CFG_SCALER_EN = 3'h3,
        CMR_CFG_RESV4     = 3'h4,
        CMR_CFG_RESV5     = 3'h5,
        CMR_CFG_RESV6     = 3'h6,
        CMR_CFG_FORCE_AUX = 3'h7
    } cmr_pin_cfg_t;

    typedef enum logic [1:0] {
        CMR_ST_INIT    = 2'h0,
        CMR_ST_ACQUIRE = 2'h1,
        CMR_ST_RUN     = 2'h3
    } cmr_state_t;

    typedef struct packed {
        logic         kit_programmed;
        cmr_pin_cfg_t pin_function_configuration;
        logic         ratio_format_select;
        logic         output_while_unlocked;
        logic         lock_pin_polarity_configuration;
    } cmr_global_t;

    typedef struct packed {
        cmr_aux_src_t auxiliary_source_select;
        logic [1:0]   ratio_scaler_select;
    } cmr_modal_t;

    typedef struct packed {
        logic [1:0] mode_sel;
        logic       special_function_pin;
    } cmr_pins_t;

endpackage

// ==== verilog/cmr_clk_gate.sv ====
`timescale 1ns/1ps
`default_nettype none

module cmr_clk_gate
    import cmr_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic clk_en,
    input  wire logic src_clk,
    input  wire logic run,
    input  wire logic drive,
    output logic      gated,
    output logic      gated_oe
);

    logic run_q;

    // run and drive only take effect while the source is low, so no high
    // phase is ever cut short or started late
    wire next_run = src_clk ? run_q : run;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            run_q    <= 1'b0;
            gated    <= 1'b0;
            gated_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            run_q    <= next_run;
            gated    <= src_clk & next_run;
            gated_oe <= src_clk ? gated_oe : drive;
        end
    end

    property p_no_runt;
        @(posedge sys_clk) disable iff (srst)
        clk_en && gated && src_clk |=> gated;
    endproperty
    a_no_runt: assert property (p_no_runt) else $error("gated high phase cut short");

    property p_oe_quiet;
        @(posedge sys_clk) disable iff (srst)
        clk_en && src_clk |=> gated_oe == $past(gated_oe);
    endproperty
    a_oe_quiet: assert property (p_oe_quiet) else $error("enable moved during high phase");

endmodule // cmr_clk_gate

`default_nettype wire

// ==== verilog/cmr_router.sv ====
// Functional notes
// - effective ratio is user ratio times scaler
// - mode pins pick one of four sets
// - special pin floats synth pin, cfg 000/010
// - synth output low while unlocked unless allowed
// - aux pin muxes reference, synth or lock
// - aux source codes: 01 ref, 10 synth, 11 lock
// - lock polarity picks indicator driver and polarity
// - polarity 0 push-pull, 1 open drain
// - unlock shown only while reference present
// - aux synth copy may lag synth pin
// - special pin floats aux pin, cfg 001/010
// - special pin high disables, low enables outputs
// - cfg 011: special pin alone enables scaler
// - cfg 111: special pin forces aux to synth
// - enable, disable, unlock never make runt pulses
// - ref and lock aux paths not glitch-free
// - mode pin change forces temporary relock
// - special pin change relocks for cfg 011-110
// - reference loss, steps, 30% drift unlock
// - kit parts need three mode toggles first
// - clock appears once locked after initialisation
// - scaler shifts right by one to four
// - format bit selects 20.12 or 12.20
`timescale 1ns/1ps
`default_nettype none
`include "cmr_defs.svh"

module cmr_router
    import cmr_pkg::*;
#(
    parameter int unsigned REF_TIMEOUT_CYC = `CMR_REF_TIMEOUT_CYC
)
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        clk_en,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire cmr_pins_t   mode_pins,
    input  wire logic        ref_clk_in,
    input  wire logic        synth_clk_in,
    input  wire logic        loop_locked,
    output logic             synth_clk_out,
    output logic             synth_clk_oe,
    output logic             aux_out,
    output logic             aux_oe,
    output logic [31:0]      effective_ratio,
    output logic             ratio_format_select,
    output logic             loop_relock
);

    ////////////////////////////////////////////////////////////////////////
    // register bus

    function automatic logic [31:0] merge_be(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
                res[8*b +: 8] = new_w[8*b +: 8];
        end
        return res;
    endfunction

    // hit flag and set index for a block of four word registers
    function automatic logic [2:0] set_slot(input logic [5:0] addr,
                                            input logic [5:0] base);
        logic [5:0] rel;
        rel = addr - base;
        return {(addr >= base) && (rel < `CMR_SET_SPAN) && (rel[1:0] == 2'h0),
                rel[3:2]};
    endfunction

    logic              ack_q;
    cmr_global_t       glb;
    cmr_modal_t        modal_mem [4];
    logic [31:0]       ratio_mem [4];
    cmr_state_t        state;
    cmr_state_t        next_state;

    wire        bus_req   = avs_read | avs_write;
    wire        bus_wr    = avs_write & ack_q;
    wire [2:0]  modal_hit = set_slot(avs_address, `CMR_OFF_MODAL0);
    wire [2:0]  ratio_hit = set_slot(avs_address, `CMR_OFF_RATIO0);
    wire        ctrl_hit  = avs_address == `CMR_OFF_CTRL;
    wire [31:0] ctrl_word = {25'h0, glb};
    wire [31:0] ctrl_new  = merge_be(ctrl_word, avs_writedata, avs_byteenable);
    // programming a kit part reopens start-up, else init would never be seen
    wire        kit_arm   = bus_wr && ctrl_hit && ctrl_new[`CMR_CTRL_KIT] && !glb.kit_programmed;

    // one wait cycle: read data is set up while waitrequest is high
    assign avs_waitrequest = bus_req & ~ack_q;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            ack_q <= 1'b0;
        else if (clk_en)
            ack_q <= bus_req & ~ack_q;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            glb <= cmr_global_t'(`CMR_CTRL_RST);
        else if (clk_en && bus_wr && ctrl_hit)
            glb <= cmr_global_t'(ctrl_new[`CMR_CTRL_KIT:0]);
    end

    // stored sets, one per mode pin code
    for (genvar g = 0; g < 4; g++)
    begin : g_set
        always_ff @(posedge sys_clk)
        begin
            if (srst)
            begin
                modal_mem[g] <= cmr_modal_t'(`CMR_MODAL_RST);
                ratio_mem[g] <= `CMR_RATIO_RST;
            end
            else if (clk_en && bus_wr)
            begin
                if (modal_hit[2] && modal_hit[1:0] == 2'(g) && avs_byteenable[0])
                    modal_mem[g] <= cmr_modal_t'(avs_writedata[`CMR_MODAL_AUX_MSB:0]);
                if (ratio_hit[2] && ratio_hit[1:0] == 2'(g))
                    ratio_mem[g] <= merge_be(ratio_mem[g], avs_writedata, avs_byteenable);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode pin decode and effective ratio

    cmr_pin_cfg_t pin_cfg;
    assign pin_cfg = glb.pin_function_configuration;

    wire        sfp        = mode_pins.special_function_pin;
    cmr_modal_t sel_modal;
    assign sel_modal = modal_mem[mode_pins.mode_sel];
    wire [31:0] user_ratio = ratio_mem[mode_pins.mode_sel];
    wire        scaler_en  = (pin_cfg == CMR_CFG_SCALER_EN) && sfp;
    wire [2:0]  shift_amt  = {1'b0, sel_modal.ratio_scaler_select} + 3'h1;
    wire [31:0] next_eff   = scaler_en ? (user_ratio >> shift_amt) : user_ratio;

    // reserved configs fall through every decode below except sfp_relock, which relocks on them
    wire synth_dis = sfp && (pin_cfg == CMR_CFG_DIS_SYNTH
                          || pin_cfg == CMR_CFG_DIS_BOTH);
    wire aux_dis   = sfp && (pin_cfg == CMR_CFG_DIS_AUX
                          || pin_cfg == CMR_CFG_DIS_BOTH);

    cmr_aux_src_t aux_sel;
    assign aux_sel = (pin_cfg == CMR_CFG_FORCE_AUX && sfp) ? CMR_AUX_SYNTH
                   : sel_modal.auxiliary_source_select;

    // format is passed on; the ratio word itself is never reinterpreted here
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            effective_ratio     <= 32'h0000_0000;
            ratio_format_select <= 1'b0;
        end
        else if (clk_en)
        begin
            effective_ratio     <= next_eff;
            ratio_format_select <= glb.ratio_format_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // unlock triggers

    logic [1:0]  mode_q;
    logic        sfp_q;
    logic        ref_q;
    logic [23:0] per_cnt;
    logic [23:0] base_per;
    logic        base_valid;
    logic        ref_present;
    logic [7:0]  relock_cnt;
    logic [1:0]  tog_cnt;

    wire        mode_chg   = mode_pins.mode_sel != mode_q;
    wire        sfp_relock = (sfp != sfp_q) && (pin_cfg == CMR_CFG_SCALER_EN
                          || (pin_cfg[2] && pin_cfg != CMR_CFG_FORCE_AUX));
    wire        ref_rise   = ref_clk_in & ~ref_q;
    wire        ref_lost   = ~ref_rise && per_cnt == 24'(REF_TIMEOUT_CYC - 1);
    wire [27:0] per_x10    = per_cnt * `CMR_DRIFT_SCALE;
    wire [27:0] base_hi    = base_per * `CMR_DRIFT_HI;
    wire [27:0] base_lo    = base_per * `CMR_DRIFT_LO;
    wire        drift      = ref_rise && base_valid
                          && (per_x10 > base_hi || per_x10 < base_lo);
    wire        relock_trig = mode_chg | sfp_relock | ref_lost | drift;
    wire        locked_int  = loop_locked && relock_cnt == 8'h00 && ref_present;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            mode_q      <= 2'h0;
            sfp_q       <= 1'b0;
            ref_q       <= 1'b0;
            per_cnt     <= 24'h00_0000;
            ref_present <= 1'b0;
        end
        else if (clk_en)
        begin
            mode_q      <= mode_pins.mode_sel;
            sfp_q       <= sfp;
            ref_q       <= ref_clk_in;
            per_cnt     <= ref_rise ? 24'h00_0000
                         : (ref_lost || !ref_present) ? per_cnt : per_cnt + 24'h00_0001;
            ref_present <= ref_rise | (ref_present & ~ref_lost);
        end
    end

    // starting period is caught on the first reference edge after lock
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            base_per   <= 24'h00_0000;
            base_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            if (state != CMR_ST_RUN)
                base_valid <= 1'b0;
            else if (ref_rise && !base_valid)
            begin
                base_per   <= per_cnt;
                base_valid <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            relock_cnt  <= 8'h00;
            loop_relock <= 1'b0;
            tog_cnt     <= 2'h0;
        end
        else if (clk_en)
        begin
            loop_relock <= relock_trig;
            relock_cnt  <= relock_trig ? 8'(`CMR_RELOCK_CYC)
                         : (relock_cnt != 8'h00) ? relock_cnt - 8'h01 : relock_cnt;
            if (kit_arm)
                tog_cnt <= 2'h0;
            else if (mode_chg && tog_cnt != `CMR_INIT_TOGGLES)
                tog_cnt <= tog_cnt + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // start-up and lock sequencing

    wire init_done = !glb.kit_programmed || tog_cnt == `CMR_INIT_TOGGLES;

    always_comb
    begin
        next_state = state;
        unique case (state)
            CMR_ST_INIT:    next_state = init_done ? CMR_ST_ACQUIRE : CMR_ST_INIT;
            CMR_ST_ACQUIRE: next_state = locked_int ? CMR_ST_RUN : CMR_ST_ACQUIRE;
            CMR_ST_RUN:     next_state = locked_int ? CMR_ST_RUN : CMR_ST_ACQUIRE;
            default:        next_state = CMR_ST_INIT;
        endcase
        if (kit_arm)
            next_state = CMR_ST_INIT;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            state <= CMR_ST_INIT;
        else if (clk_en)
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////
    // output routing

    logic aux_clk;
    logic aux_clk_oe;

    wire synth_run  = state == CMR_ST_RUN
                   || (glb.output_while_unlocked && state != CMR_ST_INIT);
    wire unlock_ind = !locked_int && ref_present;
    wire lock_od    = glb.lock_pin_polarity_configuration;

    cmr_clk_gate u_synth_gate (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .src_clk  (synth_clk_in),
        .run      (synth_run),
        .drive    (!synth_dis),
        .gated    (synth_clk_out),
        .gated_oe (synth_clk_oe)
    );

    // separate gate for the aux copy; its extra register stage lags the synth pin
    cmr_clk_gate u_aux_gate (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .src_clk  (synth_clk_in),
        .run      (synth_run),
        .drive    (!aux_dis),
        .gated    (aux_clk),
        .gated_oe (aux_clk_oe)
    );

    // ref and lock paths switch at once, so a partial period can appear there
    wire next_aux    = (aux_sel == CMR_AUX_REF)   ? ref_clk_in
                     : (aux_sel == CMR_AUX_SYNTH) ? aux_clk
                     : (aux_sel == CMR_AUX_LOCK)  ? (unlock_ind && !lock_od)
                     : 1'b0;
    wire next_aux_oe = (aux_sel == CMR_AUX_SYNTH) ? aux_clk_oe
                     : (aux_sel == CMR_AUX_LOCK && lock_od) ? (!aux_dis && unlock_ind)
                     : !aux_dis;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            aux_out <= 1'b0;
            aux_oe  <= 1'b0;
        end
        else if (clk_en)
        begin
            aux_out <= next_aux;
            aux_oe  <= next_aux_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status readback

    wire [31:0] status_word = {23'h0, aux_oe, synth_clk_oe, aux_sel, mode_pins.mode_sel,
                               state == CMR_ST_RUN, ref_present, locked_int};
    wire [31:0] next_rdata  = ctrl_hit ? ctrl_word
                            : modal_hit[2] ? {28'h0, modal_mem[modal_hit[1:0]]}
                            : ratio_hit[2] ? ratio_mem[ratio_hit[1:0]]
                            : (avs_address == `CMR_OFF_STATUS) ? status_word
                            : (avs_address == `CMR_OFF_EFFRATIO) ? effective_ratio
                            : 32'h0000_0000;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            avs_readdata <= 32'h0000_0000;
        else if (clk_en && avs_read && !ack_q)
            avs_readdata <= next_rdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_ratio_half;
        @(posedge sys_clk) disable iff (srst)
        clk_en && scaler_en && sel_modal.ratio_scaler_select == 2'h0
        |=> effective_ratio == {1'b0, $past(user_ratio[31:1])};
    endproperty
    a_ratio_half: assert property (p_ratio_half) else $error("scaler 00 not divide by 2");

    property p_ratio_sixteenth;
        @(posedge sys_clk) disable iff (srst)
        clk_en && scaler_en && sel_modal.ratio_scaler_select == 2'h3
        |=> effective_ratio == {4'h0, $past(user_ratio[31:4])};
    endproperty
    a_ratio_sixteenth: assert property (p_ratio_sixteenth) else $error("scaler 11 wrong");

    property p_no_scaler;
        @(posedge sys_clk) disable iff (srst)
        clk_en && pin_cfg != CMR_CFG_SCALER_EN |=> effective_ratio == $past(user_ratio);
    endproperty
    a_no_scaler: assert property (p_no_scaler) else $error("scaler applied without enable");

    property p_synth_float;
        @(posedge sys_clk) disable iff (srst)
        clk_en && synth_dis && !synth_clk_in |=> !synth_clk_oe;
    endproperty
    a_synth_float: assert property (p_synth_float) else $error("synth pin still driven");

    property p_synth_low_unlocked;
        @(posedge sys_clk) disable iff (srst)
        clk_en && !synth_run && !synth_clk_in ##1 clk_en && !synth_run |=> !synth_clk_out;
    endproperty
    a_synth_low_unlocked: assert property (p_synth_low_unlocked) else $error("clock while unlocked");

    property p_lock_od;
        @(posedge sys_clk) disable iff (srst)
        clk_en && aux_sel == CMR_AUX_LOCK && lock_od && !aux_dis
        |=> !aux_out && aux_oe == $past(unlock_ind);
    endproperty
    a_lock_od: assert property (p_lock_od) else $error("open-drain indicator wrong");

    property p_aux_float;
        @(posedge sys_clk) disable iff (srst)
        clk_en && aux_dis && aux_sel != CMR_AUX_SYNTH |=> !aux_oe;
    endproperty
    a_aux_float: assert property (p_aux_float) else $error("aux pin still driven");

    property p_mode_relock;
        @(posedge sys_clk) disable iff (srst)
        clk_en && mode_chg |=> loop_relock ##1 (!locked_int || !clk_en);
    endproperty
    a_mode_relock: assert property (p_mode_relock) else $error("mode change kept lock");

    property p_force_aux;
        @(posedge sys_clk) disable iff (srst)
        clk_en && pin_cfg == CMR_CFG_FORCE_AUX && sfp |=> aux_out == $past(aux_clk);
    endproperty
    a_force_aux: assert property (p_force_aux) else $error("aux override ignored");

    property p_kit_hold;
        @(posedge sys_clk) disable iff (srst)
        glb.kit_programmed && tog_cnt != `CMR_INIT_TOGGLES && state == CMR_ST_INIT
        |=> state == CMR_ST_INIT || $past(mode_chg && tog_cnt == 2'h2);
    endproperty
    a_kit_hold: assert property (p_kit_hold) else $error("left init before toggles");

endmodule // cmr_router

`default_nettype wire

// ==== bench/cmr_sys_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module cmr_sys_model
#(
    parameter int REF_HALF = 5
)
(
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic ref_on,
    input  wire logic lock_req,
    output logic      ref_clk_in,
    output logic      synth_clk_in,
    output logic      loop_locked
);
    int         ref_cnt;
    logic [1:0] syn_cnt;

    // reference held static through reset; a steady period keeps drift at zero
    always_ff @(posedge sys_clk)
    begin
        if (srst || !ref_on)
        begin
            ref_cnt    <= 0;
            ref_clk_in <= 1'b0;
        end
        else if (ref_cnt == REF_HALF - 1)
        begin
            ref_cnt    <= 0;
            ref_clk_in <= !ref_clk_in;
        end
        else
            ref_cnt <= ref_cnt + 1;
        syn_cnt      <= srst ? 2'h0 : syn_cnt + 2'h1;
        synth_clk_in <= syn_cnt[1];
        loop_locked  <= lock_req && !srst;
    end
endmodule // cmr_sys_model

`default_nettype wire

// ==== bench/test_clock_mode_output_router.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_clock_mode_output_router
    import cmr_pkg::*;
;
    logic        sys_clk, srst, clk_en, avs_read, avs_write, ref_on, lock_req, sd1, sd2, fmt;
    logic        avs_waitrequest, synth_clk_out, synth_clk_oe, aux_out, aux_oe;
    logic        ref_clk_in, synth_clk_in, loop_locked, ratio_format_select, loop_relock;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, effective_ratio, dq, r [4];
    logic [3:0]  avs_byteenable;
    logic [1:0]  rm [4];
    cmr_pins_t   mode_pins;
    int          seed = 71909;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          relock_n = 0;
    int          n0;

    cmr_router #(.REF_TIMEOUT_CYC(64)) dut (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mode_pins(mode_pins),
        .ref_clk_in(ref_clk_in), .synth_clk_in(synth_clk_in), .loop_locked(loop_locked),
        .synth_clk_out(synth_clk_out), .synth_clk_oe(synth_clk_oe), .aux_out(aux_out),
        .aux_oe(aux_oe), .effective_ratio(effective_ratio),
        .ratio_format_select(ratio_format_select), .loop_relock(loop_relock));
    cmr_sys_model sys (.sys_clk(sys_clk), .srst(srst), .ref_on(ref_on), .lock_req(lock_req),
        .ref_clk_in(ref_clk_in), .synth_clk_in(synth_clk_in), .loop_locked(loop_locked));

    always @(posedge sys_clk)
    begin
        sd1 <= synth_clk_in;
        sd2 <= sd1;
        if (loop_relock === 1'b1)
            relock_n <= relock_n + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task test_done;
        if (error_cnt == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] exp_ratio(input logic [31:0] v, input logic [1:0] s,
                                              input logic en);
        return en ? v >> (s + 3'h1) : v;
    endfunction

    // request held until the edge at which waitrequest is seen low; one idle edge after
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= d;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 50)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 50)
        begin
            error_cnt++;
            test_done;
        end
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task rdc(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    task cw(input logic [2:0] cfg, input logic f, input logic owu, input logic pol);
        logic [31:0] q;
        bus(1'b1, 6'h00, {25'h0, 1'b0, cfg, f, owu, pol}, q);
    endtask

    task tick(input int k);
        repeat (k) @(posedge sys_clk);
    endtask

    task follow(input logic aux);
        repeat (8)
        begin
            @(negedge sys_clk);
            chk(aux ? aux_out : synth_clk_out, aux ? sd2 : sd1);
            @(posedge sys_clk);
        end
    endtask

    task oe2(input logic so, input logic ao, input logic av);
        @(negedge sys_clk);
        chk(synth_clk_oe, so);
        chk(aux_oe, ao);
        chk(aux_out, av);
        @(posedge sys_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = !sys_clk;
    end

    initial
    begin
        #100000;
        error_cnt++;
        test_done;
    end

    initial
    begin
        {srst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 40'h0};
        {avs_byteenable, mode_pins, ref_on, lock_req, clk_en} = {4'hF, 3'h0, 3'h1};
        tick(8);
        srst     <= 1'b0;
        ref_on   <= 1'b1;
        lock_req <= 1'b1;
        rdc(6'h00, 32'h0);
        rdc(6'h04, 32'h4);
        rdc(6'h14, 32'h1000);
        cw(3'h0, 1'b0, 1'b0, 1'b0);
        bus(1'b1, 6'h3C, 32'hFFFF_FFFF, r[0]);
        rdc(6'h3C, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            r[i]  = $random(seed);
            rm[i] = $random(seed);
            bus(1'b1, 6'(6'h14 + 4 * i), r[i], dq);
            bus(1'b1, 6'(6'h04 + 4 * i), {28'h0, CMR_AUX_LOCK, rm[i]}, dq);
        end
        for (int k = 0; k < 16; k++)
        begin
            fmt = $random(seed);
            cw(k[3] ? 3'h4 : 3'h3, fmt, 1'b0, 1'b0);
            mode_pins <= {k[2:1], k[0]};
            tick(4);
            @(negedge sys_clk);
            chk(effective_ratio, exp_ratio(r[k[2:1]], rm[k[2:1]], !k[3] && k[0]));
            chk(ratio_format_select, fmt);
            @(posedge sys_clk);
        end
        clk_en    <= 1'b0;
        mode_pins <= 3'b010;
        tick(4);
        chk(effective_ratio, exp_ratio(r[3], rm[3], 1'b0));
        n0 = relock_n;
        clk_en <= 1'b1;
        tick(4);
        chk(relock_n - n0, 1);
        cw(3'h0, 1'b0, 1'b0, 1'b0);
        mode_pins <= 3'b000;
        n0 = 0;
        while (aux_out !== 1'b0 && n0 < 1000)
        begin
            tick(1);
            n0++;
        end
        tick(4);
        oe2(1'b1, 1'b1, 1'b0);
        follow(1'b0);
        for (int c = 0; c < 3; c++)
        begin
            cw(3'(c), 1'b0, 1'b0, 1'b0);
            mode_pins <= 3'b001;
            tick(8);
            oe2(c == 1, c == 0, 1'b0);
        end
        mode_pins <= 3'b000;
        tick(8);
        oe2(1'b1, 1'b1, 1'b0);
        cw(3'h7, 1'b0, 1'b0, 1'b0);
        mode_pins <= 3'b001;
        tick(4);
        follow(1'b1);
        mode_pins <= 3'b000;
        tick(4);
        oe2(1'b1, 1'b1, 1'b0);
        lock_req <= 1'b0;
        tick(6);
        @(negedge sys_clk);
        chk(synth_clk_out, 1'b0);
        @(posedge sys_clk);
        oe2(1'b1, 1'b1, 1'b1);
        cw(3'h0, 1'b0, 1'b0, 1'b1);
        oe2(1'b1, 1'b1, 1'b0);
        ref_on <= 1'b0;
        tick(100);
        oe2(1'b1, 1'b0, 1'b0);
        ref_on <= 1'b1;
        cw(3'h0, 1'b0, 1'b1, 1'b1);
        tick(8);
        oe2(1'b1, 1'b1, 1'b0);
        follow(1'b0);
        lock_req <= 1'b1;
        bus(1'b1, 6'h00, 32'h0000_0040, dq);
        for (int t = 0; t < 4; t++)
        begin
            tick(120);
            bus(1'b0, 6'h24, 32'h0, dq);
            chk(dq[2], t == 3);
            mode_pins <= {1'b0, !t[0], 1'b0};
        end
        test_done;
    end
endmodule // test_clock_mode_output_router

`default_nettype wire
